// ===== verilog/bsct_top.sv
// Beam smoothing and cascade trigger logic of a measuring light curtain.
// Assumes configuration inputs and serial bytes come from logic on i_sys_clk,
// while the shared trigger pin arrives asynchronously from another curtain.
`timescale 1ns/1ps
`default_nettype none
`include "bsct_map.svh"
module bsct_top import bsct_pkg::*; #(
  parameter int NB = 16,
  parameter logic [7:0] MB_ADDR = 8'h01,
  parameter int US_CYC = `BSCT_US_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire bsct_cfg_t i_cfg,
  input wire logic [NB-1:0] i_beams,
  input wire logic i_beams_valid,
  input wire logic i_par_wr,
  input wire logic [7:0] i_par_index,
  input wire logic [15:0] i_par_data,
  input wire logic i_mb_rx_valid,
  input wire logic [7:0] i_mb_rx_byte,
  input wire logic i_mb_rx_gap,
  input wire logic i_mb_tx_ready,
  input wire logic i_pin_in,
  input wire logic i_scan_done,
  output logic [NB-1:0] o_eval_beams,
  output logic o_eval_valid,
  output logic [31:0] o_thresholds,
  output logic o_mb_tx_valid,
  output logic [7:0] o_mb_tx_byte,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_scan_start,
  output logic o_scan_busy
);
  // All assertions below sample on the system clock and pause while reset is low.
  default clocking bsct_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // ==========================================================================
  // State record
  typedef struct packed {
    bsct_scan_t scan_st;
    logic [15:0] us_cnt;
    logic [9:0] ms_cnt;
    logic [15:0] per_cnt;
    logic [15:0] dly_cnt;
    logic pin_s1, pin_s2, pin_prev, trig_hi, pin_oe, scan_start;
    logic [31:0] thr;
    logic [3:0] mb_idx;
    logic mb_ok, mb_tx;
    logic [2:0] tx_idx;
    logic [5:0][7:0] hdr;
    logic [31:0] mb_data;
    logic [NB-1:0] eval;
    logic eval_vld;
  } bsct_state_t;

  bsct_state_t r_reg, r_next;

  // ==========================================================================
  // Helpers
  // Counts set bits of a beam vector.
  function automatic logic [15:0] ones(input logic [NB-1:0] v);
    logic [15:0] n;
    n = 16'h0000;
    for (int i = 0; i < NB; i++) begin
      n = n + {15'h0000, v[i]};
    end
    return n;
  endfunction

  // Expected header byte of a threshold write frame at a given position.
  function automatic logic [7:0] hdr_exp(input logic [3:0] idx);
    case (idx)
      4'h0: hdr_exp = MB_ADDR;
      4'h1: hdr_exp = `BSCT_MB_FN_WRITE;
      4'h2: hdr_exp = `BSCT_MB_REG_HI;
      4'h3: hdr_exp = `BSCT_MB_REG_LO;
      4'h4: hdr_exp = `BSCT_MB_CNT_HI;
      4'h5: hdr_exp = `BSCT_MB_CNT_LO;
      default: hdr_exp = `BSCT_MB_BYTES;
    endcase
  endfunction

  // Derived roles and timebase ticks.
  logic [15:0] n_int, n_free, thr_smooth, thr_inv;
  logic pin_inv, master_on, slave_on, us_tick, ms_tick, per_end, trig_edge, pin_lvl;

  assign n_int = ones(i_beams);
  assign n_free = 16'(NB) - n_int;
  assign thr_smooth = {8'h00, r_reg.thr[`BSCT_OFS_SMOOTH +: 8]};
  assign thr_inv = {8'h00, r_reg.thr[`BSCT_OFS_INV +: 8]};
  assign pin_inv = (i_cfg.io_switch != `BSCT_SW_LIGHT);
  assign master_on = i_cfg.cascade_en && i_cfg.func_master
                     && (i_cfg.io_func == `BSCT_IO_TRIG_OUT);
  assign slave_on = i_cfg.cascade_en && !i_cfg.func_master
                    && (i_cfg.io_func == `BSCT_IO_TRIG_IN);
  assign us_tick = (r_reg.us_cnt == 16'(US_CYC - 1));
  assign ms_tick = us_tick && (r_reg.ms_cnt == 10'(`BSCT_MS_US - 1));
  assign per_end = ms_tick && (r_reg.per_cnt + 16'h0001 >= i_cfg.period_ms);
  assign pin_lvl = r_reg.pin_s2 ^ pin_inv;
  assign trig_edge = pin_lvl && !r_reg.pin_prev;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.scan_start = 1'b0;
    r_next.eval_vld = 1'b0;
    // Timebase: microsecond prescaler and millisecond divider.
    r_next.us_cnt = us_tick ? 16'h0000 : r_reg.us_cnt + 16'h0001;
    if (us_tick) begin
      r_next.ms_cnt = (r_reg.ms_cnt == 10'(`BSCT_MS_US - 1)) ? 10'h000 : r_reg.ms_cnt + 10'h001;
    end
    // Pin synchroniser; only the second stage is looked at.
    r_next.pin_s1 = i_pin_in;
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.pin_prev = pin_lvl;
    // Smoothing on each new beam image.
    if (i_beams_valid) begin
      r_next.eval = (n_int >= thr_smooth) ? i_beams : '0;
      if (n_free < thr_inv) begin
        r_next.eval = r_next.eval | ~i_beams;
      end
      r_next.eval_vld = 1'b1;
    end
    // Master: periodic trigger pulse one microsecond wide, and own scan.
    r_next.pin_oe = master_on;
    if (!master_on) begin
      r_next.per_cnt = 16'h0000;
      r_next.trig_hi = 1'b0;
    end else begin
      if (us_tick) begin
        r_next.trig_hi = 1'b0;
      end
      if (per_end) begin
        r_next.per_cnt = 16'h0000;
        r_next.trig_hi = 1'b1;
        r_next.scan_start = 1'b1;
      end else if (ms_tick) begin
        r_next.per_cnt = r_reg.per_cnt + 16'h0001;
      end
    end
    // Slave sequencer: trigger, delay, one scan.
    case (r_reg.scan_st)
      BSCT_IDLE: begin
        if (slave_on && trig_edge) begin
          r_next.dly_cnt = 16'h0000;
          if (i_cfg.delay_us == 16'h0000) begin
            r_next.scan_st = BSCT_SCAN;
            r_next.scan_start = 1'b1;
          end else begin
            r_next.scan_st = BSCT_DELAY;
          end
        end
      end
      BSCT_DELAY: begin
        if (us_tick) begin
          r_next.dly_cnt = r_reg.dly_cnt + 16'h0001;
          if (r_reg.dly_cnt + 16'h0001 >= i_cfg.delay_us) begin
            r_next.scan_st = BSCT_SCAN;
            r_next.scan_start = 1'b1;
          end
        end
      end
      BSCT_SCAN: begin
        if (i_scan_done) begin
          r_next.scan_st = BSCT_IDLE;
        end
      end
      default: begin
        r_next.scan_st = BSCT_IDLE;
      end
    endcase
    // Sensor link parameter write of both thresholds.
    if (i_par_wr && i_par_index == `BSCT_PAR_IDX_SMOOTH) begin
      r_next.thr = {16'h0000, i_par_data};
    end
    // Serial frame receiver; bytes are ignored while the echo is sent.
    if (r_reg.mb_tx) begin
      if (i_mb_tx_ready) begin
        r_next.tx_idx = r_reg.tx_idx + 3'h1;
        if (r_reg.tx_idx == `BSCT_MB_ECHO_LAST) begin
          r_next.mb_tx = 1'b0;
        end
      end
    end else if (i_mb_rx_gap) begin
      r_next.mb_idx = 4'h0;
      r_next.mb_ok = 1'b1;
    end else if (i_mb_rx_valid && r_reg.mb_idx <= `BSCT_MB_LAST_IDX) begin
      r_next.mb_idx = r_reg.mb_idx + 4'h1;
      if (r_reg.mb_idx <= 4'h6 && i_mb_rx_byte != hdr_exp(r_reg.mb_idx)) begin
        r_next.mb_ok = 1'b0;
      end
      if (r_reg.mb_idx <= 4'h5) begin
        r_next.hdr[r_reg.mb_idx[2:0]] = i_mb_rx_byte;
      end
      if (r_reg.mb_idx >= 4'h7 && r_reg.mb_idx <= 4'ha) begin
        r_next.mb_data = {r_reg.mb_data[23:0], i_mb_rx_byte};
      end
      if (r_reg.mb_idx == `BSCT_MB_LAST_IDX && r_reg.mb_ok) begin
        r_next.thr = r_reg.mb_data;
        r_next.mb_tx = 1'b1;
        r_next.tx_idx = 3'h0;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
      r_reg.scan_st <= BSCT_IDLE;
      r_reg.mb_ok <= 1'b1;
      r_reg.thr <= `BSCT_THR_RESET;
    end else begin
      r_reg <= r_next;
    end
  end
  // Outputs; the echo byte is selected from the captured header.
  assign o_eval_beams = r_reg.eval;
  assign o_eval_valid = r_reg.eval_vld;
  assign o_thresholds = r_reg.thr;
  assign o_mb_tx_valid = r_reg.mb_tx;
  assign o_mb_tx_byte = r_reg.hdr[r_reg.tx_idx];
  assign o_pin_out = r_reg.pin_oe && (r_reg.trig_hi ^ pin_inv);
  assign o_pin_oe = r_reg.pin_oe;
  assign o_scan_start = r_reg.scan_start;
  assign o_scan_busy = (r_reg.scan_st != BSCT_IDLE);
  // ==========================================================================
  // Assertions
  property p_smooth_drop;
    i_beams_valid && n_int < thr_smooth && n_free >= thr_inv |=> o_eval_beams == '0;
  endproperty
  a_smooth_drop: assert property (p_smooth_drop) else $error("isolated hits kept");
  property p_smooth_keep;
    i_beams_valid && n_int >= thr_smooth && n_free >= thr_inv
    |=> o_eval_valid && o_eval_beams == $past(i_beams);
  endproperty
  a_smooth_keep: assert property (p_smooth_keep) else $error("hits lost");
  property p_inv_drop;
    i_beams_valid && n_free < thr_inv |=> (o_eval_beams & ~$past(i_beams)) == ~$past(i_beams);
  endproperty
  a_inv_drop: assert property (p_inv_drop) else $error("isolated free beams kept");
  property p_par_write;
    i_par_wr && i_par_index == 8'h47 && !(r_reg.mb_idx == 4'hc && i_mb_rx_valid)
    |=> o_thresholds[15:8] == $past(i_par_data[15:8]) && o_thresholds[7:0] == $past(i_par_data[7:0]);
  endproperty
  a_par_write: assert property (p_par_write) else $error("threshold write lost");
  property p_mb_echo;
    $rose(o_mb_tx_valid) |-> o_mb_tx_byte == MB_ADDR && r_reg.hdr[1] == 8'h10
      && r_reg.hdr[3] == 8'h47 && r_reg.hdr[5] == 8'h02;
  endproperty
  a_mb_echo: assert property (p_mb_echo) else $error("bad echo header");
  property p_pin_oe;
    o_pin_out |-> o_pin_oe ##0 $past(master_on);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin driven without master role");
  property p_trig_polarity;
    o_pin_oe && i_cfg.io_switch == 8'h00 |-> o_pin_out == r_reg.trig_hi;
  endproperty
  a_trig_polarity: assert property (p_trig_polarity) else $error("wrong pin polarity");
  property p_master_trig;
    master_on && per_end |=> r_reg.trig_hi && o_scan_start ##1 !o_scan_start [*8];
  endproperty
  a_master_trig: assert property (p_master_trig) else $error("master trigger wrong");
  property p_slave_scan;
    o_scan_start && !i_cfg.func_master |-> r_reg.scan_st == BSCT_SCAN;
  endproperty
  a_slave_scan: assert property (p_slave_scan) else $error("slave scanned untriggered");
  property p_one_scan;
    r_reg.scan_st == BSCT_SCAN && !i_scan_done |=> r_reg.scan_st == BSCT_SCAN && !r_reg.scan_start;
  endproperty
  a_one_scan: assert property (p_one_scan) else $error("scan retriggered");
  property p_delay;
    r_reg.scan_st == BSCT_DELAY && !(us_tick && r_reg.dly_cnt + 16'h0001 >= i_cfg.delay_us)
    |=> r_reg.scan_st == BSCT_DELAY && !o_scan_start;
  endproperty
  a_delay: assert property (p_delay) else $error("scan before delay ended");
endmodule
`default_nettype wire

// ===== inc/bsct_map.svh
// Constants for the beam smoothing and cascade trigger block.
// Assumes the includer works at the 50 MHz system clock.
`ifndef BSCT_MAP_SVH
`define BSCT_MAP_SVH
// Parameter index and bit offsets of the two thresholds on the sensor link.
`define BSCT_PAR_IDX_SMOOTH 8'h47
`define BSCT_OFS_SMOOTH 8
`define BSCT_OFS_INV 0
`define BSCT_THR_RESET 32'h0000_0000
// Serial link frame layout for the threshold write.
`define BSCT_MB_FN_WRITE 8'h10
`define BSCT_MB_REG_HI 8'h00
`define BSCT_MB_REG_LO 8'h47
`define BSCT_MB_CNT_HI 8'h00
`define BSCT_MB_CNT_LO 8'h02
`define BSCT_MB_BYTES 8'h04
`define BSCT_MB_LAST_IDX 4'hc
`define BSCT_MB_ECHO_LAST 3'h5
// Shared pin function and switching codes.
`define BSCT_IO_TRIG_OUT 8'h03
`define BSCT_IO_TRIG_IN 8'h01
`define BSCT_SW_LIGHT 8'h00
// Timing: clock period, one microsecond, one millisecond in microseconds.
`define BSCT_CLK_NS 20
`define BSCT_US_NS 1000
`define BSCT_US_CYC (`BSCT_US_NS / `BSCT_CLK_NS)
`define BSCT_MS_US 1000
`endif

// ===== inc/bsct_pkg.sv
// Types shared by the beam smoothing and cascade trigger block.
// Assumes nothing beyond a SystemVerilog compiler.
package bsct_pkg;
  // One-hot states of the slave scan sequencer.
  typedef enum logic [2:0] {
    BSCT_IDLE = 3'b001,
    BSCT_DELAY = 3'b010,
    BSCT_SCAN = 3'b100
  } bsct_scan_t;
  // Cascade and shared pin configuration, driven by the configuration logic.
  typedef struct packed {
    logic cascade_en;
    logic func_master;
    logic [15:0] period_ms;
    logic [15:0] delay_us;
    logic [7:0] io_func;
    logic [7:0] io_switch;
  } bsct_cfg_t;
endpackage

// ===== tb/bsct_peer.sv
// Far-side model: a cascade peer curtain on the shared pin and an echo consumer.
// Assumes it runs on the same system clock as the block under test.
`timescale 1ns/1ps
`default_nettype none
module bsct_peer (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_ready,
  output logic o_pin
);
  logic [7:0] rx_q [$];
  logic toggle = 1'b0;
  // ==========================================================================
  // Echo consumer: a byte is taken only at an edge where valid and ready are high.
  initial begin
    o_pin = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      rx_q.push_back(i_tx_byte);
    end
    toggle <= ~toggle;
  end
  // A slow consumer is ready only every other cycle.
  assign o_tx_ready = ~i_slow | toggle;
  // Trigger source: a master curtain raising the pin for the given cycles.
  task automatic pulse(input int cyc);
    @(posedge i_clk);
    #1 o_pin = 1'b1;
    repeat (cyc) @(posedge i_clk);
    #1 o_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/beam_smoothing_and_cascade_trigger_tb.sv
// Self-checking bench for the beam smoothing and cascade trigger block.
// Assumes a shortened microsecond (US cycles) and the peer model beside it.
`timescale 1ns/1ps
`default_nettype none
module beam_smoothing_and_cascade_trigger_tb;
  import bsct_pkg::*;
  localparam int US = 2;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  bsct_cfg_t cfg = '0;
  logic [15:0] beams = '0;
  logic bv = 1'b0, par_wr = 1'b0, rxv = 1'b0, gap = 1'b0, done = 1'b0, slow = 1'b0;
  logic [7:0] par_idx = '0, rxb = '0, txb;
  logic [15:0] par_data = '0, eval;
  logic [31:0] thr;
  logic ev, txv, ready, pout, poe, sstart, sbusy, ppin, pin;
  int mismatches = 0, comparisons = 0, n, k;
  // ==========================================================================
  // Clock, pin resolution, block and peer.
  always #10 clk = ~clk;
  assign pin = poe ? pout : ppin;
  bsct_top #(.US_CYC(US)) uut (.i_sys_clk(clk), .i_rstn(rstn), .i_cfg(cfg),
    .i_beams(beams), .i_beams_valid(bv), .i_par_wr(par_wr), .i_par_index(par_idx),
    .i_par_data(par_data), .i_mb_rx_valid(rxv), .i_mb_rx_byte(rxb), .i_mb_rx_gap(gap),
    .i_mb_tx_ready(ready), .i_pin_in(pin), .i_scan_done(done), .o_eval_beams(eval),
    .o_eval_valid(ev), .o_thresholds(thr), .o_mb_tx_valid(txv), .o_mb_tx_byte(txb),
    .o_pin_out(pout), .o_pin_oe(poe), .o_scan_start(sstart), .o_scan_busy(sbusy));
  bsct_peer peer (.i_clk(clk), .i_slow(slow), .i_tx_valid(txv), .i_tx_byte(txb),
    .o_tx_ready(ready), .o_pin(ppin));
  // ==========================================================================
  // Shared tasks: stepping, comparing, waiting and the verdict.
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_start(input int lim, output int cnt);
    cnt = 0;
    while (sstart !== 1'b1) begin
      tick;
      cnt++;
      if (cnt > lim) begin
        mismatches++;
        $display("mismatch at %0t: scan start timeout", $time);
        results;
      end
    end
  endtask
  task automatic count_starts(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      tick;
      cnt += (sstart === 1'b1);
    end
  endtask
  task automatic par(input logic [7:0] idx, input logic [15:0] d);
    par_idx = idx;
    par_data = d;
    par_wr = 1'b1;
    tick;
    par_wr = 1'b0;
    tick;
  endtask
  task automatic smooth(input logic [15:0] b, input logic [15:0] exp);
    beams = b;
    bv = 1'b1;
    tick;
    bv = 1'b0;
    check(ev, 1'b1, "eval valid");
    check(eval, exp, "eval beams");
    tick;
  endtask
  task automatic frame(input logic [103:0] f);
    gap = 1'b1;
    tick;
    gap = 1'b0;
    rxv = 1'b1;
    for (int i = 0; i < 13; i++) begin
      rxb = f[103 - 8 * i -: 8];
      tick;
    end
    rxv = 1'b0;
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_param;
    check(thr, 32'h0000_0000, "reset thresholds");
    par(8'h48, 16'h1234);
    check(thr, 32'h0000_0000, "other index");
    par(8'h47, 16'h0401);
    check(thr, 32'h0000_0401, "index 71");
    par(8'h47, 16'h0203);
    check(thr, 32'h0000_0203, "back to back");
    $display("test param done");
  endtask
  task automatic t_smooth;
    par(8'h47, 16'h0400);
    smooth(16'h0007, 16'h0000);
    smooth(16'h000f, 16'h000f);
    par(8'h47, 16'h0004);
    smooth(16'h1fff, 16'hffff);
    smooth(16'h0fff, 16'h0fff);
    $display("test smooth done");
  endtask
  task automatic t_serial;
    slow = 1'b1;
    frame(104'h02_10_0047_0002_04_00000401_7579);
    tick;
    check(txv, 1'b0, "foreign address echo");
    check(thr, 32'h0000_0004, "foreign address dropped");
    frame(104'h01_10_0047_0002_04_00000401_7579);
    check(txv, 1'b1, "echo valid");
    check(thr, 32'h0000_0401, "serial thresholds");
    for (k = 0; k < 40 && peer.rx_q.size() < 6; k++) tick;
    if (peer.rx_q.size() < 6) begin
      mismatches++;
      $display("mismatch at %0t: echo timeout", $time);
      results;
    end
    tick;
    check(txv, 1'b0, "echo ends");
    check(peer.rx_q.size(), 6, "echo length");
    for (int i = 0; i < 6; i++) begin
      check(peer.rx_q[i], 48'h01_10_0047_0002 >> (40 - 8 * i) & 8'hff, "echo byte");
    end
    slow = 1'b0;
    $display("test serial done");
  endtask
  task automatic t_master;
    cfg = '{1'b1, 1'b1, 16'd1, 16'd0, 8'h03, 8'h00};
    wait_start(3000, n);
    check(poe, 1'b1, "master drives pin");
    check(pout, 1'b1, "pin rises with start");
    tick;
    wait_start(2500, n);
    check(n + 1, 1000 * US, "trigger period");
    repeat (US) tick;
    check(pout, 1'b0, "trigger pulse ends");
    cfg.io_switch = 8'h01;
    tick;
    check(pout, 1'b1, "inverted idle level");
    cfg = '{1'b0, 1'b1, 16'd1, 16'd0, 8'h03, 8'h00};
    count_starts(2500, n);
    check(n, 0, "no trigger when disabled");
    $display("test master done");
  endtask
  task automatic t_slave;
    cfg = '{1'b1, 1'b0, 16'd1, 16'd5, 8'h01, 8'h00};
    tick;
    check(poe, 1'b0, "slave releases pin");
    peer.pulse(US);
    wait_start(30, n);
    check((n + US >= 5 * US) && (n + US <= 5 * US + 6), 1'b1, "scan delay");
    tick;
    check(sbusy, 1'b1, "busy after start");
    peer.pulse(US);
    count_starts(30, n);
    check(n, 0, "trigger while busy");
    done = 1'b1;
    tick;
    done = 1'b0;
    tick;
    check(sbusy, 1'b0, "idle after done");
    peer.pulse(US);
    count_starts(30, n);
    check(n, 1, "one scan per trigger");
    $display("test slave done");
  endtask
  // ==========================================================================
  // Main sequence: reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    t_param;
    t_smooth;
    t_serial;
    t_master;
    t_slave;
    results;
  end
endmodule
`default_nettype wire
